// ---- dv/sfr_bus_model.sv ----
// Far side of the serial bus: header receiver select plus a data sender.
// The link clock only runs while a task is busy and rests high in between.
module sfr_bus_model (
    output logic serialBusClk,
    output logic serDatIn,
    output logic rxSelect,
    input wire logic serDatOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic senderOne = 1'b0;
    logic oeAt [272];
    // Open-drain wired-OR; the pull-up makes a released line read high
    assign serDatIn = ~(senderOne | serDatOe);
    initial begin
        serialBusClk = 1'b1;
        rxSelect = 1'b0;
    end
    // Bit i of the frame goes out on the change edge; drive level seen just before the sample edge
    task automatic send(input logic [271:0] v, input int n, input logic sel);
        for (int i = 0; i < n; i++) begin
            serialBusClk = 1'b0;
            #1;
            senderOne = v[n-1-i];
            rxSelect = sel && (i == 0);
            #31;
            oeAt[i] = serDatOe;
            serialBusClk = 1'b1;
            #32;
        end
        senderOne = 1'b0;
    endtask
    task automatic idle(input int n);
        send('0, n, 1'b0);
    endtask
endmodule

// ---- dv/sfr_data_receiver_tb.sv ----
module sfr_data_receiver_tb import sfr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MB = 2;
    localparam int DW = MB * BITS_PER_BYTE;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic readBusy = 1'b0;
    logic overlapClear = 1'b0;
    logic serialBusClk, serDatIn, rxSelect, serDatOut, serDatOe, rxNewData, rxOverlap;
    logic [DW-1:0] rxData;
    logic [FT_W-1:0] rxSize;
    logic roOe, roNew, roOverlap;
    logic [DW-1:0] roData;
    logic [FT_W-1:0] roSize;
    logic driveDiff = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int newCnt = 0;
    int roCnt = 0;
    logic [DW-1:0] lastD = '0;
    logic [FT_W-1:0] lastS = '0;

    always #2 core_clk = ~core_clk;
    // Sampled mid-cycle so the pulse is never read in its launching time step
    always @(negedge core_clk) if (rxNewData === 1'b1) newCnt <= newCnt + 1;
    always @(negedge core_clk) if (roNew === 1'b1) roCnt <= roCnt + 1;
    // Both builds see the same frames, so their line drive must agree bit for bit
    always @(posedge serialBusClk) if (roOe !== serDatOe) driveDiff <= 1'b1;

    sfr_data_receiver #(.MAX_BYTES(MB), .READ_ONCE(1'b0)) dut (.core_clk(core_clk),
        .rst_n(rst_n), .serialBusClk(serialBusClk), .serDatIn(serDatIn), .rxSelect(rxSelect),
        .readBusy(readBusy), .overlapClear(overlapClear), .serDatOut(serDatOut),
        .serDatOe(serDatOe), .rxData(rxData), .rxSize(rxSize), .rxNewData(rxNewData),
        .rxOverlap(rxOverlap));
    // Read-once build on the same bus; its drive joins the wired-OR line
    sfr_data_receiver #(.MAX_BYTES(MB), .READ_ONCE(1'b1)) dutRo (.core_clk(core_clk),
        .rst_n(rst_n), .serialBusClk(serialBusClk), .serDatIn(serDatIn), .rxSelect(rxSelect),
        .readBusy(readBusy), .overlapClear(overlapClear), .serDatOut(),
        .serDatOe(roOe), .rxData(roData), .rxSize(roSize), .rxNewData(roNew),
        .rxOverlap(roOverlap));
    sfr_bus_model bus (.serialBusClk(serialBusClk), .serDatIn(serDatIn), .rxSelect(rxSelect),
        .serDatOe(serDatOe | roOe));

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic [271:0] pres(input int nb);
        return 272'h1 << (6 + nb);
    endfunction

    function automatic logic [271:0] errPat(input int nb);
        return 272'h5 << (4 + nb);
    endfunction

    // st holds status bit 2, status bit 1 and jam as driven by the far side
    task automatic frame(input logic sel, input logic [2:0] ft, input logic [31:0] d, input int nb,
            input logic [2:0] st, input logic [271:0] expOe, input logic expNew,
            input logic [DW-1:0] expD);
        logic [271:0] v;
        int n;
        int c0;
        v = {268'h0, 1'b1, ft};
        v = (v << nb) | 272'(d);
        v = (v << 4) | {268'h0, st[2], st[1], 1'b0, st[0]};
        v = v << 1;
        n = nb + 9;
        c0 = newCnt;
        bus.send(v, n, sel);
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < n; i++) check(bus.oeAt[i] === expOe[i], "line drive");
        check(serDatOut === 1'b0, "open-drain output level");
        check(driveDiff === 1'b0, "read-once line drive");
        check(newCnt == c0 + (expNew ? 1 : 0), "new data pulse count");
        if (expNew) begin
            lastD = expD;
            lastS = ft;
        end
        check(rxData === lastD && rxSize === lastS, "data or size port");
        check(roCnt == newCnt && roData === lastD && roSize === lastS, "read-once port");
    endtask

    task automatic t_reset_values;
        check(serDatOe === 1'b0 && rxNewData === 1'b0 && rxOverlap === 1'b0, "reset out");
        check(rxData === '0 && rxSize === SIZE_RST, "reset data");
        check(roData === '0 && roSize === SIZE_RST && roOe === 1'b0, "read-once reset");
    endtask

    task automatic t_good_frames;
        frame(1'b1, 3'h1, 32'hA5, 8, 3'b010, pres(8), 1'b1, 16'h00A5);
        frame(1'b1, 3'h2, 32'h3C96, 16, 3'b010, pres(16), 1'b1, 16'h3C96);
        frame(1'b1, 3'h1, 32'h7E, 8, 3'b010, pres(8), 1'b1, 16'h007E);
        check(rxOverlap === 1'b0, "overlap without busy read");
    endtask

    task automatic t_status_fail;
        frame(1'b1, 3'h2, 32'h1234, 16, 3'b110, '0, 1'b0, '0);
        frame(1'b1, 3'h1, 32'h5A, 8, 3'b000, pres(8), 1'b0, '0);
        frame(1'b1, 3'h1, 32'hC3, 8, 3'b011, pres(8), 1'b0, '0);
    endtask

    task automatic t_special_types;
        // A receiver whose onboard logic has dropped accept only sees cancelled frames
        frame(1'b1, FT_CANCEL, 32'h0, 0, 3'b000, '0, 1'b0, '0);
        frame(1'b1, FT_NONE, 32'h0, 0, 3'b000, errPat(0), 1'b0, '0);
    endtask

    // Types 3 to 6 exceed a two-byte build and must be waited out
    task automatic t_oversize;
        int nb;
        for (int ft = 3; ft <= 6; ft++) begin
            nb = 8 << (ft - 1);
            frame(1'b1, 3'(ft), 32'h0, nb, 3'b000, errPat(nb), 1'b0, '0);
        end
    endtask

    task automatic t_unselected;
        frame(1'b0, 3'h1, 32'h99, 8, 3'b010, '0, 1'b0, '0);
    endtask

    // Onboard logic reads whenever it likes and ignores the pulse
    task automatic t_overlap;
        @(posedge core_clk) readBusy <= 1'b1;
        frame(1'b1, 3'h2, 32'hBEEF, 16, 3'b010, pres(16), 1'b1, 16'hBEEF);
        check(rxOverlap === 1'b1 && roOverlap === 1'b1, "overlap not flagged");
        @(posedge core_clk) readBusy <= 1'b0;
        overlapClear <= 1'b1;
        @(posedge core_clk) overlapClear <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(rxOverlap === 1'b0 && roOverlap === 1'b0, "overlap not cleared");
    endtask

    task automatic t_reset_midrun;
        @(posedge core_clk) rst_n <= 1'b0;
        bus.idle(3);
        lastD = '0;
        lastS = '0;
        frame(1'b1, FT_NONE, 32'h0, 0, 3'b000, '0, 1'b0, '0);
        @(posedge core_clk) rst_n <= 1'b1;
        bus.idle(3);
        frame(1'b1, 3'h1, 32'h3C, 8, 3'b010, pres(8), 1'b1, 16'h003C);
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // About four times the expected run; a stuck link would never end otherwise
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    initial begin
        // Reset must span link edges as well as the six core cycles
        fork
            bus.idle(4);
            repeat (6) @(posedge core_clk);
        join
        t_reset_values();
        @(posedge core_clk) rst_n <= 1'b1;
        bus.idle(3);
        t_good_frames();
        t_status_fail();
        t_special_types();
        t_oversize();
        t_unselected();
        t_overlap();
        t_reset_midrun();
        report_and_stop();
    end
endmodule

// ---- src/sfr_commit_sync.sv ----
module sfr_commit_sync import sfr_pkg::*; #(
    parameter int DW = 256
) (
    input wire logic core_clk,
    input wire logic rst_n,
    sfr_xing_if.dst xing,
    output logic [DW-1:0] rxData,
    output logic [FT_W-1:0] rxSize,
    output logic rxNewData
);
    logic tgl1_q;
    logic tgl2_q;
    logic tgl3_q;
    wire commitSeen = tgl2_q ^ tgl3_q;

    // Link data is static long before the toggle settles, so words cross unsynchronised
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tgl1_q <= 1'b0;
            tgl2_q <= 1'b0;
            tgl3_q <= 1'b0;
        end else begin
            tgl1_q <= xing.commitTgl;
            tgl2_q <= tgl1_q;
            tgl3_q <= tgl2_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxData <= '0;
            rxSize <= SIZE_RST;
            rxNewData <= 1'b0;
        end else begin
            rxNewData <= commitSeen;
            if (commitSeen) begin
                rxData <= xing.data;
                rxSize <= xing.size;
            end
        end
    end

    a_commit_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
        commitSeen |=> rxNewData && rxSize == $past(xing.size) && rxData == $past(xing.data))
        else $error("committed frame not presented");
endmodule

// ---- src/sfr_data_receiver.sv ----
module sfr_data_receiver import sfr_pkg::*; #(
    parameter int MAX_BYTES = MAX_BYTES_DEF,
    parameter bit READ_ONCE = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serialBusClk,
    input wire logic serDatIn,
    input wire logic rxSelect,
    input wire logic readBusy,
    input wire logic overlapClear,
    output logic serDatOut,
    output logic serDatOe,
    output logic [MAX_BYTES*BITS_PER_BYTE-1:0] rxData,
    output logic [FT_W-1:0] rxSize,
    output logic rxNewData,
    output logic rxOverlap
);
    localparam int DW = MAX_BYTES * BITS_PER_BYTE;

    if (MAX_BYTES < 1 || MAX_BYTES > MAX_BYTES_LIMIT) begin : g_bad_size
        $error("MAX_BYTES must lie between 1 and 32");
    end

    // Link reset: system reset brought onto the serial clock
    logic lRst1_q;
    logic lRst2_q;
    wire linkRun = lRst2_q;

    always_ff @(posedge serialBusClk) begin
        lRst1_q <= rst_n;
        lRst2_q <= lRst1_q;
    end

    // Sample edge: capture select and line; line low is a one
    logic selSmp_q;
    logic lineSmp_q;

    always_ff @(posedge serialBusClk) begin
        if (!linkRun) begin
            selSmp_q <= 1'b0;
            lineSmp_q <= 1'b0;
        end else begin
            selSmp_q <= rxSelect;
            lineSmp_q <= ~serDatIn;
        end
    end

    // Change edge: frame state machine consumes the last sample and drives
    sfr_state_t state_q;
    logic [FT_W-1:0] typ_q;
    logic [1:0] idx_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] bitsTgt_q;
    logic bit1_q;
    logic [DW-1:0] hold_q;
    logic [DW-1:0] dataReg_q;
    logic [FT_W-1:0] sizeReg_q;
    logic commitTgl_q;
    logic oe_q;
    logic outLvl_q;

    wire [FT_W-1:0] typeNow = {typ_q[FT_W-2:0], lineSmp_q};
    wire [FT_W-1:0] typeIdx = typeNow - FT_ONE_BYTE;
    wire [CNT_W-1:0] frameBits = CNT_W'(BITS_PER_BYTE) << typeIdx;
    wire [5:0] frameBytes = 6'h01 << typeIdx;
    // Oversized frames are waited out in full so the status field still lines up
    wire supported = int'(frameBytes) <= MAX_BYTES;
    wire typeDone = idx_q == TYPE_LAST_IDX;
    wire lastBit = cnt_q == bitsTgt_q - CNT_W'(1);
    wire startSeen = selSmp_q && lineSmp_q;
    wire commitOk = bit1_q && !lineSmp_q;
    wire [DW-1:0] shiftBase = READ_ONCE ? dataReg_q : hold_q;
    wire [DW-1:0] shifted = {shiftBase[DW-2:0], lineSmp_q};
    wire errBit = ERR_PATTERN[2'h2 - idx_q];

    always_ff @(negedge serialBusClk) begin
        if (!linkRun) begin
            state_q <= SFR_IDLE;
            oe_q <= 1'b0;
            typ_q <= FT_NONE;
            idx_q <= 2'h0;
            cnt_q <= '0;
            bitsTgt_q <= '0;
            bit1_q <= 1'b0;
        end else begin
            unique case (state_q)
                SFR_IDLE: begin
                    oe_q <= 1'b0;
                    idx_q <= 2'h0;
                    if (startSeen) begin
                        state_q <= SFR_TYPE;
                    end
                end
                SFR_TYPE: begin
                    typ_q <= typeNow;
                    idx_q <= idx_q + 2'h1;
                    cnt_q <= '0;
                    bitsTgt_q <= frameBits;
                    if (typeDone) begin
                        if (typeNow == FT_CANCEL) begin
                            state_q <= SFR_IDLE;
                        end else if (typeNow == FT_NONE) begin
                            state_q <= SFR_ERR;
                            oe_q <= ERR_PATTERN[2];
                            idx_q <= 2'h1;
                        end else if (supported) begin
                            state_q <= SFR_DATA;
                        end else begin
                            state_q <= SFR_SKIP;
                        end
                    end
                end
                SFR_DATA: begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (lastBit) begin
                        state_q <= SFR_ST2;
                    end
                end
                SFR_SKIP: begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (lastBit) begin
                        state_q <= SFR_ERR;
                        oe_q <= ERR_PATTERN[2];
                        idx_q <= 2'h1;
                    end
                end
                SFR_ERR: begin
                    idx_q <= idx_q + 2'h1;
                    if (idx_q == ERR_LAST_IDX) begin
                        oe_q <= 1'b0;
                        state_q <= SFR_IDLE;
                    end else begin
                        oe_q <= errBit;
                    end
                end
                SFR_ST2: begin
                    oe_q <= 1'b0;
                    state_q <= lineSmp_q ? SFR_IDLE : SFR_ST1;
                end
                SFR_ST1: begin
                    bit1_q <= lineSmp_q;
                    oe_q <= 1'b1;
                    state_q <= SFR_PRES;
                end
                SFR_PRES: begin
                    oe_q <= 1'b0;
                    state_q <= SFR_JAM;
                end
                SFR_JAM: begin
                    oe_q <= 1'b0;
                    state_q <= SFR_IDLE;
                end
                default: begin
                    oe_q <= 1'b0;
                    state_q <= SFR_IDLE;
                end
            endcase
        end
    end

    // Data path on the change edge; size and toggle move only on a clean commit, read-once data also when cleared at type decode and while it shifts
    always_ff @(negedge serialBusClk) begin
        if (!linkRun) begin
            hold_q <= '0;
            dataReg_q <= '0;
            sizeReg_q <= SIZE_RST;
            commitTgl_q <= 1'b0;
            outLvl_q <= 1'b0;
        end else begin
            outLvl_q <= 1'b0;
            if (state_q == SFR_TYPE && typeDone && supported) begin
                if (READ_ONCE) begin
                    dataReg_q <= '0;
                end else begin
                    hold_q <= '0;
                end
            end
            if (state_q == SFR_DATA) begin
                if (READ_ONCE) begin
                    dataReg_q <= shifted;
                end else begin
                    hold_q <= shifted;
                end
            end
            if (state_q == SFR_JAM && commitOk) begin
                if (!READ_ONCE) begin
                    dataReg_q <= hold_q;
                end
                sizeReg_q <= typ_q;
                commitTgl_q <= ~commitTgl_q;
            end
        end
    end

    // Open-drain pin: a one is the line pulled low
    assign serDatOut = outLvl_q;
    assign serDatOe = oe_q;

    // Read-once builds drop the arrival strobe on a failed status exchange;
    // here a failed exchange never toggles, so no strobe reaches the core side.
    sfr_xing_if #(.DW(DW)) xing ();

    assign xing.commitTgl = commitTgl_q;
    assign xing.data = dataReg_q;
    assign xing.size = sizeReg_q;

    sfr_commit_sync #(.DW(DW)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .xing(xing),
        .rxData(rxData),
        .rxSize(rxSize),
        .rxNewData(rxNewData)
    );

    // Always-ready use: readBusy marks a multi-word read; fresh data during it
    // is flagged. A new event in the clear cycle keeps the flag set.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxOverlap <= 1'b0;
        end else begin
            rxOverlap <= (rxNewData && readBusy) || (rxOverlap && !overlapClear);
        end
    end

    a_idle_wait_start: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_IDLE && !startSeen |=> state_q == SFR_IDLE && !oe_q)
        else $error("left idle without select and start");

    a_cancel_quiet: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_TYPE && typeDone && typeNow == FT_CANCEL
        |=> state_q == SFR_IDLE && !oe_q)
        else $error("cancelled frame not dropped quietly");

    a_none_pattern: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_TYPE && typeDone && typeNow == FT_NONE
        |=> oe_q ##1 !oe_q ##1 oe_q ##1 (!oe_q && state_q == SFR_IDLE))
        else $error("no-sender pattern 101 wrong");

    a_oversize_wait: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_SKIP |-> !oe_q && $stable(dataReg_q))
        else $error("oversized frame disturbed line or data");

    a_status2_abort: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_ST2 && lineSmp_q |=> state_q == SFR_IDLE && !oe_q)
        else $error("status bit 2 one did not abandon");

    a_presence_drive: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_ST1 |=> oe_q ##1 (!oe_q && state_q == SFR_JAM))
        else $error("presence bit drive or release wrong");

    a_status_released: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q inside {SFR_ST2, SFR_ST1, SFR_DATA, SFR_JAM} |-> !oe_q)
        else $error("line driven during a sampled status bit");

    a_fail_no_update: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_JAM && !commitOk
        |=> $stable(sizeReg_q) && $stable(commitTgl_q) && state_q == SFR_IDLE)
        else $error("failed frame changed outputs");

    a_commit_copy: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_JAM && commitOk
        |=> sizeReg_q == $past(typ_q) && commitTgl_q != $past(commitTgl_q))
        else $error("successful frame not committed");

    // Onboard logic may clear the flag right after it shows, so holding is checked apart
    a_overlap_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        rxNewData && readBusy |=> rxOverlap)
        else $error("overlap not flagged");

    a_overlap_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        rxOverlap && !overlapClear |=> rxOverlap)
        else $error("overlap flag lost without clear");

    a_reset_quiet: assert property (@(negedge serialBusClk)
        !linkRun |=> !oe_q)
        else $error("line driven during reset");

    a_reset_clear: assert property (@(negedge serialBusClk)
        !linkRun |=> sizeReg_q == SIZE_RST && dataReg_q == '0)
        else $error("output registers not cleared in reset");

    a_type_length: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_IDLE && startSeen |=> (state_q == SFR_TYPE) [*3] ##1 state_q != SFR_TYPE)
        else $error("frame type not three bits long");

    a_data_shift: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_DATA |=> (READ_ONCE ? dataReg_q[0] : hold_q[0]) == $past(lineSmp_q))
        else $error("data bit not shifted in");

    a_oversize_pattern: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_SKIP && lastBit |=> oe_q ##1 !oe_q ##1 oe_q ##1 (!oe_q && state_q == SFR_IDLE))
        else $error("oversize pattern 101 wrong");

    a_status1_keep: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        state_q == SFR_ST1 |=> bit1_q == $past(lineSmp_q))
        else $error("status bit 1 not kept");

    a_size_hold: assert property (@(negedge serialBusClk) disable iff (!linkRun)
        !(state_q == SFR_JAM && commitOk) |=> $stable(sizeReg_q) && $stable(commitTgl_q))
        else $error("size or commit moved without a clean frame");
endmodule

// ---- src/sfr_pkg.sv ----
// Functional notes
// - While reset is low, release the data line and ignore its level.
// - Reset clears the received-data and size output registers to zero.
// - After reset release the receiver enters idle.
// - Idle samples select and line each sample edge; leaves on select and one.
// - Next three sample edges give frame type: 001..110 sizes, 000 none, 111 cancel.
// - Frame type 111 returns straight to idle without driving.
// - Frame type 000 drives 101 on three change edges, releases, goes idle.
// - Oversized frame waits its bytes out, then drives 101, releases, goes idle.
// - Supported frame shifts bytes into staging, MSB of leftmost byte first.
// - Sample after last data bit is status bit 2; a one abandons the frame.
// - If status bit 2 is zero, sample and keep status bit 1.
// - Next change edge drives a one as status bit 0.
// - Following change edge releases the line; next sample is jam detect.
// - Bit 1 zero or jam one discards the frame, outputs unchanged.
// - Bit 1 one and jam zero commits staging data and type code.
// - Read-once build shifts straight into the output data register.
// - Always-ready use flags new data arriving during a multi-read.
// - Data is captured only when receive select marks this receiver.
package sfr_pkg;
    localparam int FT_W = 3;
    localparam logic [FT_W-1:0] FT_NONE = 3'h0;
    localparam logic [FT_W-1:0] FT_ONE_BYTE = 3'h1;
    localparam logic [FT_W-1:0] FT_CANCEL = 3'h7;
    localparam logic [FT_W-1:0] ERR_PATTERN = 3'h5;
    localparam logic [FT_W-1:0] SIZE_RST = 3'h0;
    localparam int BITS_PER_BYTE = 8;
    localparam int MAX_BYTES_DEF = 32;
    localparam int MAX_BYTES_LIMIT = 32;
    localparam int CNT_W = 9;
    localparam logic [1:0] TYPE_LAST_IDX = 2'h2;
    localparam logic [1:0] ERR_LAST_IDX = 2'h3;

    typedef enum logic [3:0] {
        SFR_IDLE = 4'h0,
        SFR_TYPE = 4'h1,
        SFR_DATA = 4'h2,
        SFR_SKIP = 4'h3,
        SFR_ERR = 4'h4,
        SFR_ST2 = 4'h5,
        SFR_ST1 = 4'h6,
        SFR_PRES = 4'h7,
        SFR_JAM = 4'h8
    } sfr_state_t;
endpackage

// ---- src/sfr_xing_if.sv ----
interface sfr_xing_if #(parameter int DW = 256);
    logic commitTgl;
    logic [DW-1:0] data;
    logic [2:0] size;
    modport src (output commitTgl, output data, output size);
    modport dst (input commitTgl, input data, input size);
endinterface
